/* File: verilog/lcdid_pkg.sv */
// constants, field layouts and types of the lcd instruction decoder
package lcdid_pkg;
    // ****************************************
    // register map and geometry
    // ****************************************
    localparam logic [3:0]  ADDR_CMD   = 4'h0;
    localparam logic [3:0]  ADDR_DATA  = 4'h4;
    localparam logic [7:0]  COL_MAX    = 8'h83;
    localparam logic [7:0]  LINE_MAX   = 8'hBF;
    localparam logic [11:0] COLS       = 12'h084;
    localparam logic [4:0]  PAGES      = 5'h18;
    localparam int          RAM_DEPTH  = 3168;
    localparam logic [3:0]  RST_CYC    = 4'h8;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0]  BIAS_RST   = 4'h8;
    localparam logic [2:0]  BOOST_RST  = 3'h4;
    localparam logic [7:0]  EVR_RST    = 8'hFF;
    localparam logic [4:0]  UNITS_FULL = 5'h10;
    // ****************************************
    // opcodes, main table
    // ****************************************
    localparam logic [6:0]  OP_DISP    = 7'h57;
    localparam logic [6:0]  OP_NORM    = 7'h53;
    localparam logic [6:0]  OP_WHOLE   = 7'h52;
    localparam logic [6:0]  OP_ADC     = 7'h50;
    localparam logic [6:0]  OP_RMW     = 7'h70;
    localparam logic [6:0]  OP_PWR     = 7'h10;
    localparam logic [6:0]  OP_VSET    = 7'h11;
    localparam logic [7:0]  OP_RESET   = 8'hE2;
    localparam logic [7:0]  OP_SUB     = 8'h70;
    localparam logic [4:0]  OP_BOOST   = 5'h06;
    localparam logic [3:0]  N_COL_LO   = 4'h0;
    localparam logic [3:0]  N_COL_HI   = 4'h1;
    localparam logic [3:0]  N_PAGE_HI  = 4'h4;
    localparam logic [3:0]  N_LINE_HI  = 4'h5;
    localparam logic [3:0]  N_LINE_LO  = 4'h6;
    localparam logic [3:0]  N_BIAS     = 4'hB;
    localparam logic [3:0]  N_PAGE_LO  = 4'hC;
    // ****************************************
    // opcodes, sub table
    // ****************************************
    localparam logic [3:0]  N_B1_START = 4'h0;
    localparam logic [2:0]  N_B1_CNT   = 3'h1;
    localparam logic [3:0]  N_B2_START = 4'hC;
    localparam logic [2:0]  N_B2_CNT   = 3'h7;
    localparam logic [7:0]  OP_PON     = 8'h40;
    localparam logic [3:0]  N_LINV_HI  = 4'h5;
    localparam logic [3:0]  N_LINV_LO  = 4'h6;
    localparam logic [7:0]  OP_LINV_GO = 8'h70;
    localparam logic [7:0]  OP_END     = 8'h71;
    localparam logic [3:0]  N_EVR_HI   = 4'h8;
    localparam logic [3:0]  N_EVR_LO   = 4'h9;
    localparam logic [7:0]  OP_EVR_GO  = 8'hA0;

    typedef enum logic {TBL_MAIN = 1'b0, TBL_SUB = 1'b1} lcdid_tbl_t;

    typedef struct packed {
        logic       disp_on;
        logic       seg_rev;
        logic       inverse;
        logic       all_on;
        logic       pwr_save;
        logic       int_pwr;
        logic       vset;
        logic [3:0] bias;
        logic [2:0] boost;
        logic [7:0] start_line;
        logic       partial;
        logic [3:0] b1_start;
        logic [4:0] b1_cnt;
        logic [3:0] b2_start;
        logic [4:0] b2_cnt;
        logic [4:0] units;
        logic [5:0] line_inv;
        logic [7:0] evr;
    } lcdid_cfg_t;

    localparam lcdid_cfg_t CFG_RST = '{
        bias: BIAS_RST, boost: BOOST_RST, units: UNITS_FULL,
        evr: EVR_RST, default: '0};
endpackage : lcdid_pkg

/* File: verilog/lcdid_core.sv */
// lcd instruction decoder, display ram and avalon-mm slave
`timescale 1ns/1ps
// ****************************************
// ****************************************
module lcdid_core #(
    parameter logic [3:0] RST_CYC = lcdid_pkg::RST_CYC
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // avalon-mm slave
    input  wire logic [3:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output      logic [31:0]           avs_readdata,
    output      logic                  avs_waitrequest,
    // interface strap
    input  wire logic                  psel_serial,
    // display scan side
    input  wire logic [11:0]           scan_idx,
    output      logic [7:0]            scan_data,
    output      lcdid_pkg::lcdid_cfg_t cfg,
    output      logic                  busy
);
    // ****************************************
    // state
    // ****************************************
    logic                   wait_ff;
    logic                   busy_ff;
    logic [3:0]             bcnt_ff;
    logic [7:0]             rdata_ff;
    logic [7:0]             col_ff;
    logic [7:0]             rmw_col_ff;
    logic                   rmw_ff;
    logic [4:0]             page_ff;
    logic [7:0]             latch_ff;
    logic [7:0]             scan_ff;
    logic [5:0]             linv_sh_ff;
    logic [7:0]             evr_sh_ff;
    lcdid_pkg::lcdid_tbl_t  tbl_ff;
    lcdid_pkg::lcdid_cfg_t  cfg_ff;
    logic [7:0]             ram [0:lcdid_pkg::RAM_DEPTH-1];

    // ****************************************
    // bus decode
    // ****************************************
    logic        req;
    logic        is_cmd;
    logic        is_dat;
    logic        stall;
    logic        acc;
    logic        wr_ok;
    logic        mc;
    logic        sc;
    logic [7:0]  cmd;
    logic        dwr_acc;
    logic        drd_acc;
    logic        soft_rst;
    logic        init;
    logic        in_ram;
    logic [11:0] idx;
    logic [7:0]  status;
    logic [5:0]  usum;
    logic        full;

    assign req     = avs_read | avs_write;
    assign is_cmd  = avs_address == lcdid_pkg::ADDR_CMD;
    assign is_dat  = avs_address == lcdid_pkg::ADDR_DATA;
    // status polling stays open while busy
    assign stall   = busy_ff & ~(avs_read & is_cmd);
    assign acc     = req & ~wait_ff;
    assign wr_ok   = avs_write & avs_byteenable[0];
    assign cmd     = avs_writedata[7:0];
    assign mc      = acc & wr_ok & is_cmd
                   & (tbl_ff == lcdid_pkg::TBL_MAIN);
    assign sc      = acc & wr_ok & is_cmd
                   & (tbl_ff == lcdid_pkg::TBL_SUB);
    assign dwr_acc = acc & wr_ok & is_dat;
    // serial hosts cannot read back ram
    assign drd_acc = acc & avs_read & is_dat & ~psel_serial;
    assign soft_rst = mc & (cmd == lcdid_pkg::OP_RESET);
    assign init    = ~rstn | soft_rst;
    assign in_ram  = page_ff < lcdid_pkg::PAGES;
    assign idx     = 12'(page_ff) * lcdid_pkg::COLS
                   + 12'(col_ff);
    assign status  = {busy_ff, ~cfg_ff.seg_rev, ~cfg_ff.disp_on,
                      busy_ff, 4'h0};
    assign usum    = 6'(cfg_ff.b1_cnt) + 6'(cfg_ff.b2_cnt);
    assign full    = (cfg_ff.b1_start == 4'h0)
                   & (cfg_ff.b2_cnt == lcdid_pkg::UNITS_FULL);

    assign avs_readdata    = {24'h000000, rdata_ff};
    assign avs_waitrequest = wait_ff;
    assign scan_data       = scan_ff;
    assign cfg             = cfg_ff;
    assign busy            = busy_ff;

    function automatic logic [7:0] col_lim(input logic [7:0] v);
        col_lim = (v > lcdid_pkg::COL_MAX) ? lcdid_pkg::COL_MAX : v;
    endfunction : col_lim

    // ****************************************
    // handshake and read data
    // ****************************************
    // one wait cycle, more while busy stalls a non-status request; it gives the ram a registered read
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wait_ff <= 1'b1;
        end else if (!wait_ff) begin
            wait_ff <= 1'b1;
        end else if (req && !stall) begin
            wait_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else if (avs_read && wait_ff && !stall) begin
            if (is_cmd) begin
                rdata_ff <= status;
            end else if (is_dat && !psel_serial) begin
                rdata_ff <= latch_ff;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // ****************************************
    // reset cycle
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (init) begin
            bcnt_ff <= RST_CYC;
            busy_ff <= 1'b1;
        end else if (bcnt_ff != 4'h0) begin
            bcnt_ff <= bcnt_ff - 4'h1;
            busy_ff <= bcnt_ff != 4'h1;
        end
    end

    // ****************************************
    // instruction table select
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tbl_ff <= lcdid_pkg::TBL_MAIN;
        end else if (mc && cmd == lcdid_pkg::OP_SUB) begin
            tbl_ff <= lcdid_pkg::TBL_SUB;
        end else if (sc && cmd == lcdid_pkg::OP_END) begin
            tbl_ff <= lcdid_pkg::TBL_MAIN;
        end
    end

    // ****************************************
    // address counters
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (init) begin
            col_ff     <= 8'h00;
            page_ff    <= 5'h00;
            rmw_ff     <= 1'b0;
            rmw_col_ff <= 8'h00;
        end else if (mc && cmd[7:4] == lcdid_pkg::N_PAGE_HI) begin
            page_ff[4] <= cmd[0];
        end else if (mc && cmd[7:4] == lcdid_pkg::N_PAGE_LO) begin
            page_ff[3:0] <= cmd[3:0];
        end else if (mc && cmd[7:4] == lcdid_pkg::N_COL_HI) begin
            // column set is not allowed inside rmw
            if (!rmw_ff) begin
                col_ff <= col_lim({cmd[3:0], col_ff[3:0]});
            end
        end else if (mc && cmd[7:4] == lcdid_pkg::N_COL_LO) begin
            if (!rmw_ff) begin
                col_ff <= col_lim({col_ff[7:4], cmd[3:0]});
            end
        end else if (mc && cmd[7:1] == lcdid_pkg::OP_RMW) begin
            if (!cmd[0]) begin
                rmw_ff     <= 1'b1;
                rmw_col_ff <= col_ff;
            end else if (rmw_ff) begin
                rmw_ff <= 1'b0;
                col_ff <= rmw_col_ff;
            end
        end else if (dwr_acc || (drd_acc && !rmw_ff)) begin
            if (col_ff != lcdid_pkg::COL_MAX) begin
                col_ff <= col_ff + 8'h01;
            end
        end
    end

    // ****************************************
    // display ram
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (dwr_acc && in_ram) begin
            ram[idx] <= cmd;
        end
    end

    // read latch gives the dummy read after an address change
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            latch_ff <= 8'h00;
            scan_ff  <= 8'h00;
        end else begin
            if (drd_acc) begin
                latch_ff <= in_ram ? ram[idx] : 8'h00;
            end
            scan_ff <= (32'(scan_idx) < lcdid_pkg::RAM_DEPTH)
                     ? ram[scan_idx] : 8'h00;
        end
    end

    // ****************************************
    // display and power settings
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg_ff     <= lcdid_pkg::CFG_RST;
            linv_sh_ff <= 6'h00;
            evr_sh_ff  <= lcdid_pkg::EVR_RST;
        end else if (soft_rst) begin
            cfg_ff.start_line <= 8'h00;
            cfg_ff.units      <= lcdid_pkg::UNITS_FULL;
            cfg_ff.partial    <= 1'b0;
            cfg_ff.bias       <= lcdid_pkg::BIAS_RST;
            cfg_ff.boost      <= lcdid_pkg::BOOST_RST;
            cfg_ff.line_inv   <= 6'h00;
            cfg_ff.evr        <= lcdid_pkg::EVR_RST;
        end else if (mc) begin
            if (cmd[7:1] == lcdid_pkg::OP_DISP) begin
                cfg_ff.disp_on <= cmd[0];
                if (cmd[0]) begin
                    cfg_ff.pwr_save <= 1'b0;
                end
            end else if (cmd[7:1] == lcdid_pkg::OP_WHOLE) begin
                cfg_ff.all_on <= cmd[0];
                if (cmd[0] && !cfg_ff.disp_on) begin
                    cfg_ff.pwr_save <= 1'b1;
                end else if (!cmd[0]) begin
                    cfg_ff.pwr_save <= 1'b0;
                end
            end else if (cmd[7:1] == lcdid_pkg::OP_NORM) begin
                cfg_ff.inverse <= cmd[0];
            end else if (cmd[7:1] == lcdid_pkg::OP_ADC) begin
                cfg_ff.seg_rev <= cmd[0];
            end else if (cmd[7:1] == lcdid_pkg::OP_PWR) begin
                cfg_ff.int_pwr <= cmd[0];
            end else if (cmd[7:1] == lcdid_pkg::OP_VSET) begin
                // only meaningful once the supply is up
                cfg_ff.vset <= cmd[0] & cfg_ff.int_pwr;
            end else if (cmd[7:4] == lcdid_pkg::N_LINE_HI) begin
                if ({cmd[3:0], cfg_ff.start_line[3:0]}
                        <= lcdid_pkg::LINE_MAX) begin
                    cfg_ff.start_line[7:4] <= cmd[3:0];
                end
            end else if (cmd[7:4] == lcdid_pkg::N_LINE_LO) begin
                cfg_ff.start_line[3:0] <= cmd[3:0];
            end else if (cmd[7:4] == lcdid_pkg::N_BIAS) begin
                cfg_ff.bias <= cmd[3] ? lcdid_pkg::BIAS_RST
                                      : cmd[3:0];
            end else if (cmd[7:3] == lcdid_pkg::OP_BOOST) begin
                cfg_ff.boost <= cmd[2] ? lcdid_pkg::BOOST_RST
                                       : cmd[2:0];
            end
        end else if (sc) begin
            if (cmd[7:4] == lcdid_pkg::N_B1_START) begin
                cfg_ff.b1_start <= cmd[3:0];
            end else if (cmd[7:5] == lcdid_pkg::N_B1_CNT) begin
                cfg_ff.b1_cnt <= cmd[4:0];
            end else if (cmd[7:4] == lcdid_pkg::N_B2_START) begin
                cfg_ff.b2_start <= cmd[3:0];
            end else if (cmd[7:5] == lcdid_pkg::N_B2_CNT) begin
                cfg_ff.b2_cnt <= cmd[4:0];
            end else if (cmd == lcdid_pkg::OP_PON) begin
                // duty follows the active unit count
                cfg_ff.partial <= ~full;
                if (full || usum > 6'(lcdid_pkg::UNITS_FULL)) begin
                    cfg_ff.units <= lcdid_pkg::UNITS_FULL;
                end else begin
                    cfg_ff.units <= usum[4:0];
                end
            end else if (cmd[7:4] == lcdid_pkg::N_LINV_HI) begin
                linv_sh_ff[5:4] <= cmd[1:0];
            end else if (cmd[7:4] == lcdid_pkg::N_LINV_LO) begin
                linv_sh_ff[3:0] <= cmd[3:0];
            end else if (cmd == lcdid_pkg::OP_LINV_GO) begin
                cfg_ff.line_inv <= linv_sh_ff;
            end else if (cmd[7:4] == lcdid_pkg::N_EVR_HI) begin
                evr_sh_ff[7:4] <= cmd[3:0];
            end else if (cmd[7:4] == lcdid_pkg::N_EVR_LO) begin
                evr_sh_ff[3:0] <= cmd[3:0];
            end else if (cmd == lcdid_pkg::OP_EVR_GO) begin
                cfg_ff.evr <= evr_sh_ff;
            end
        end
        // anything else falls through untouched
    end

    // ****************************************
    // checks
    // ****************************************
    AST_ANSWER_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
        (req && wait_ff && !stall) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_COL_STEP: assert property (@(posedge core_clk) disable iff (!rstn)
        (dwr_acc && col_ff < lcdid_pkg::COL_MAX)
        |=> col_ff == $past(col_ff) + 8'h01)
        else $error("column did not step after data write");
    AST_COL_SAT: assert property (@(posedge core_clk) disable iff (!rstn)
        (dwr_acc && col_ff == lcdid_pkg::COL_MAX)
        |=> col_ff == lcdid_pkg::COL_MAX && $stable(page_ff))
        else $error("column or page moved at last column");
    AST_RMW_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        (drd_acc && rmw_ff) |=> $stable(col_ff))
        else $error("read moved column in rmw mode");
    AST_STATUS: assert property (@(posedge core_clk) disable iff (!rstn)
        (avs_read && is_cmd && wait_ff)
        |=> avs_readdata[3:0] == 4'h0
            && avs_readdata[6] == !cfg_ff.seg_rev
            && avs_readdata[5] == !cfg_ff.disp_on)
        else $error("status byte wrong");
    AST_SOFT_INIT: assert property (@(posedge core_clk) disable iff (!rstn)
        soft_rst |=> col_ff == 8'h00 && page_ff == 5'h00
            && cfg_ff.start_line == 8'h00
            && cfg_ff.bias == lcdid_pkg::BIAS_RST
            && cfg_ff.boost == lcdid_pkg::BOOST_RST
            && cfg_ff.units == lcdid_pkg::UNITS_FULL)
        else $error("soft reset left state");
    AST_BUSY_END: assert property (@(posedge core_clk) disable iff (!rstn)
        soft_rst |=> busy_ff ##[1:16] !busy_ff)
        else $error("reset cycle busy wrong");
    AST_PSAVE: assert property (@(posedge core_clk) disable iff (!rstn)
        (mc && cmd[7:1] == lcdid_pkg::OP_WHOLE && cmd[0]
            && !cfg_ff.disp_on) |=> cfg_ff.pwr_save && cfg_ff.all_on)
        else $error("power save not entered");
    AST_FULL_DUTY: assert property (@(posedge core_clk) disable iff (!rstn)
        (sc && cmd == lcdid_pkg::OP_PON && full)
        |=> cfg_ff.units == lcdid_pkg::UNITS_FULL && !cfg_ff.partial)
        else $error("full display duty wrong");
    AST_RMW_BACK: assert property (@(posedge core_clk) disable iff (!rstn)
        (mc && cmd[7:1] == lcdid_pkg::OP_RMW && cmd[0] && rmw_ff)
        |=> col_ff == $past(rmw_col_ff) && !rmw_ff)
        else $error("rmw end did not restore column");
endmodule : lcdid_core

/* File: verification/lcdid_host.sv */
// host-side avalon-mm master model for the lcd decoder
`timescale 1ns/1ps
module lcdid_host (
    // clock
    input  wire logic        core_clk,
    // avalon-mm master side
    output      logic [3:0]  avs_address,
    output      logic        avs_read,
    output      logic        avs_write,
    output      logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic [7:0] rd_byte;
    initial begin
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end
    // held until waitrequest low is sampled, then one idle edge
    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd_byte = avs_readdata[7:0];
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        // released data must not look valid
        avs_writedata <= ~avs_writedata;
        @(posedge core_clk);
    endtask : xfer
    // poll status, nothing else goes out while busy
    task automatic wait_ready();
        rd_byte = 8'h80;
        while (rd_byte[7] !== 1'b0) begin
            xfer(1'b0, lcdid_pkg::ADDR_CMD, 8'h00);
        end
    endtask : wait_ready
endmodule : lcdid_host

/* File: verification/tb.sv */
// self-checking bench for the lcd instruction decoder
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [2:0] kind;
        logic [7:0] dat;
    } lcdid_row_t;
    localparam logic [2:0] KC = 3'h0;
    localparam logic [2:0] KD = 3'h1;
    localparam logic [2:0] KS = 3'h2;
    localparam logic [2:0] KR = 3'h3;
    localparam logic [2:0] KM = 3'h7;
    logic                  core_clk;
    logic                  rstn;
    logic [3:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic                  psel_serial;
    logic [11:0]           scan_idx;
    logic [7:0]            scan_data;
    lcdid_pkg::lcdid_cfg_t cfg;
    logic                  busy;
    int                    miscompares;
    int                    num_checks;
    int                    cycles;
    logic [7:0]            q[$];
    lcdid_row_t            rows[30];

    lcdid_core #(.RST_CYC(4'h8)) u_dut (
        .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .psel_serial(psel_serial), .scan_idx(scan_idx),
        .scan_data(scan_data), .cfg(cfg), .busy(busy));
    lcdid_host u_host (
        .core_clk(core_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input logic [7:0] cmds[$]);
        foreach (cmds[i]) u_host.xfer(1'b1, lcdid_pkg::ADDR_CMD, cmds[i]);
    endtask : send
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // generous ceiling, the whole run needs well under 2000 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        psel_serial = 1'b0;
        scan_idx = 12'h18A;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        rows = '{'{KS,8'h60}, '{KC,8'hAF}, '{KS,8'h40}, '{KC,8'hA1},
            '{KS,8'h00}, '{KC,8'hA0}, '{KC,8'hC2}, '{KC,8'h18},
            '{KC,8'h02}, '{KD,8'h11}, '{KD,8'h22}, '{KD,8'h33},
            '{KC,8'h18}, '{KC,8'h02}, '{KM,8'h00}, '{KR,8'h11},
            '{KR,8'h33}, '{KR,8'h33}, '{KC,8'h18}, '{KC,8'h02},
            '{KC,8'hE0}, '{KM,8'h00}, '{KR,8'h11}, '{KR,8'h11},
            '{KD,8'h55}, '{KC,8'hE1}, '{KM,8'h00}, '{KR,8'h55},
            '{KC,8'hFF}, '{KS,8'h40}};
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        u_host.wait_ready();
        // page is set before any data access
        foreach (rows[i]) begin
            u_host.xfer(~rows[i].kind[1], rows[i].kind[0] ?
                lcdid_pkg::ADDR_DATA : lcdid_pkg::ADDR_CMD, rows[i].dat);
            if (rows[i].kind == KS) begin
                check(u_host.rd_byte, rows[i].dat);
            end else if (rows[i].kind == KR) begin
                check(u_host.rd_byte, rows[i].dat);
            end
        end
        check(scan_data, 8'h55);
        // ****************************************
        // settings, sub table, soft reset
        // ****************************************
        q = '{8'hB3, 8'h31, 8'h22};
        send(q);
        check(cfg.bias, 4'h3);
        check(cfg.boost, 3'h1);
        check(cfg.vset, 1'b0);
        q = '{8'h21, 8'h23, 8'hBC, 8'h5B, 8'h6F, 8'h5C};
        send(q);
        check(cfg.vset, 1'b1);
        check(cfg.bias, 4'h8);
        check(cfg.start_line, 8'hBF);
        q = '{8'hAE, 8'hA5, 8'hA7, 8'hB3};
        send(q);
        check({cfg.pwr_save, cfg.all_on}, 2'h3);
        check(cfg.inverse, 1'b1);
        // stray main code inside the sub table is dropped
        q = '{8'h70, 8'hAF, 8'h00, 8'h22, 8'hC4, 8'hE5, 8'h40, 8'h71};
        send(q);
        check(cfg.disp_on, 1'b0);
        check({cfg.partial, cfg.units}, 6'h27);
        // full display, then line inversion and contrast via shadows
        q = '{8'h70, 8'h00, 8'hF0, 8'h40, 8'h52, 8'h6A, 8'h70,
              8'h8C, 8'h93, 8'hA0, 8'h71};
        send(q);
        check({cfg.partial, cfg.units}, 6'h10);
        check({cfg.line_inv, cfg.evr}, 14'h2AC3);
        q = '{8'hE2};
        send(q);
        u_host.wait_ready();
        check({cfg.bias, cfg.boost}, 7'h44);
        check(cfg.start_line, 8'h00);
        check(cfg.units, 5'h10);
        check({cfg.line_inv, cfg.evr}, 14'h00FF);
        q = '{8'hC2, 8'h18, 8'h02};
        send(q);
        u_host.xfer(1'b0, lcdid_pkg::ADDR_DATA, 8'h00);
        u_host.xfer(1'b0, lcdid_pkg::ADDR_DATA, 8'h00);
        check(u_host.rd_byte, 8'h55);
        psel_serial <= 1'b1;
        u_host.xfer(1'b0, lcdid_pkg::ADDR_DATA, 8'h00);
        check(u_host.rd_byte, 8'h00);
        psel_serial <= 1'b0;
        u_host.xfer(1'b1, 4'h8, 8'hAF);
        u_host.xfer(1'b0, 4'h8, 8'h00);
        check(u_host.rd_byte, 8'h00);
        u_host.xfer(1'b0, lcdid_pkg::ADDR_CMD, 8'h00);
        check(u_host.rd_byte, 8'h60);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        u_host.xfer(1'b0, lcdid_pkg::ADDR_CMD, 8'h00);
        check(u_host.rd_byte, 8'hF0);
        check(busy, 1'b1);
        u_host.wait_ready();
        check(busy, 1'b0);
        end_of_test();
    end
endmodule : tb
